// ---- cbt_map.svh ----
// register map, field positions, reset values and timing constants for the bit timing block
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH
// Notes on behaviour
// RULE_01 - timing register writable only in init mode
// RULE_02 - bit7 sample select, 6:4 seg2, 3:0 seg1
// RULE_03 - single sample mode: bit equals sample-point sample
// RULE_04 - three sample mode: majority of three samples
// RULE_05 - three samples need phase buffer one >= 2 Tq
// RULE_06 - prefer single sample at high bit rates
// RULE_07 - seg2 length is code plus one; 000 invalid
// RULE_08 - seg1 length is code plus one; 0000-0010 invalid
// RULE_09 - bit period is (1+seg1+seg2) times prescale
// RULE_10 - segments fix bit length and sample point
// RULE_11 - six-bit prescaler divides by code plus one
// RULE_12 - init active when request and acknowledge both high
// RULE_13 - sync quantum, seg1, sample, then seg2
`define CBT_OFS_CTRL      12'h000
`define CBT_OFS_PRESCALE  12'h002
`define CBT_OFS_TIMING    12'h003
`define CBT_OFS_STATUS    12'h004
`define CBT_OFS_COUNT     12'h005
`define CBT_TIM_SAMPLE_COUNT_SELECT_BIT  7
`define CBT_TIM_SEG2_HI   6
`define CBT_TIM_SEG2_LO   4
`define CBT_TIM_SEG1_HI   3
`define CBT_TIM_SEG1_LO   0
`define CBT_TIM_RESET     8'h00
`define CBT_PRE_RESET     6'h00
`define CBT_SEG2_MIN      3'h1
`define CBT_SEG1_MIN      4'h3
`define CBT_ACK_DELAY     2
`endif

// ---- cbt_pkg.sv ----
// types shared by the bit timing block
package cbt_pkg;
	typedef enum logic [1:0] {
		CBT_SYNC = 2'b00,
		CBT_SEG1 = 2'b01,
		CBT_SEG2 = 2'b10
	} cbt_phase_e;
endpackage

// ---- cbt_bit_timing.sv ----
// bit timing segment generator with apb register slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "cbt_map.svh"
module cbt_bit_timing
	import cbt_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        can_rx,
	output logic             rx_bit,
	output logic             rx_bit_valid,
	output logic             tq_tick,
	output logic             init_acknowledge
);
	logic        init_request_q;
	logic        init_ack_q;
	logic [1:0]  ack_cnt_q;
	logic [5:0]  tq_prescaler_q;
	logic [7:0]  timing_q;
	logic [5:0]  pre_cnt_q;
	logic [3:0]  tq_cnt_q;
	cbt_phase_e  phase_q;
	logic [2:0]  sample_count_select_q;
	logic        rx_s1_q;
	logic        rx_s2_q;
	logic        init_active;
	logic        wr_en;
	logic        tick;
	logic        sample_count_select;
	logic [2:0]  phase_segment_two_len;
	logic [3:0]  segment_one_len;
	logic [3:0]  seg_last;
	logic        seg_done;

	function automatic logic majority3(input logic [2:0] s);
		majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
		// offsets are word indices; each register owns one aligned 32-bit word
		addr_is = (a == {ofs[9:0], 2'b00});
	endfunction

	assign sample_count_select   = timing_q[`CBT_TIM_SAMPLE_COUNT_SELECT_BIT]; // [RULE_02]
	assign phase_segment_two_len = timing_q[`CBT_TIM_SEG2_HI:`CBT_TIM_SEG2_LO]; // [RULE_02]
	assign segment_one_len       = timing_q[`CBT_TIM_SEG1_HI:`CBT_TIM_SEG1_LO]; // [RULE_02]
	assign init_active = init_request_q & init_ack_q; // [RULE_12]
	assign wr_en = psel & penable & pwrite;

	// apb: zero wait states, byte address is four times the register index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel & ~penable & ~pwrite) begin
				if (addr_is(paddr, `CBT_OFS_CTRL)) begin
					prdata <= {31'h0, init_request_q};
				end else if (addr_is(paddr, `CBT_OFS_PRESCALE)) begin
					prdata <= {26'h0, tq_prescaler_q};
				end else if (addr_is(paddr, `CBT_OFS_TIMING)) begin
					prdata <= {24'h0, timing_q};
				end else if (addr_is(paddr, `CBT_OFS_STATUS)) begin
					prdata <= {28'h0, phase_q, rx_bit, init_ack_q};
				end else if (addr_is(paddr, `CBT_OFS_COUNT)) begin
					prdata <= {28'h0, tq_cnt_q};
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_request_q <= 1'b0;
		end else if (wr_en && pready && addr_is(paddr, `CBT_OFS_CTRL)) begin
			init_request_q <= pwdata[0];
		end
	end

	// acknowledge follows request after a short settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_cnt_q  <= 2'h0;
			init_ack_q <= 1'b0;
		end else if (init_request_q != init_ack_q) begin
			if (ack_cnt_q == 2'(`CBT_ACK_DELAY)) begin
				ack_cnt_q  <= 2'h0;
				init_ack_q <= init_request_q; // [RULE_12]
			end else begin
				ack_cnt_q <= ack_cnt_q + 2'h1;
			end
		end else begin
			ack_cnt_q <= 2'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timing_q       <= `CBT_TIM_RESET; // [RULE_02]
			tq_prescaler_q <= `CBT_PRE_RESET;
		end else if (wr_en && pready && init_active) begin // [RULE_01]
			if (addr_is(paddr, `CBT_OFS_TIMING)) begin
				timing_q <= pwdata[7:0];
			end else if (addr_is(paddr, `CBT_OFS_PRESCALE)) begin
				tq_prescaler_q <= pwdata[5:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= can_rx;
			rx_s2_q <= rx_s1_q;
		end
	end

	// quantum prescaler: divide by code plus one; held in init
	assign tick = ~init_active && (pre_cnt_q == tq_prescaler_q); // [RULE_11]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_q <= 6'h00;
			tq_tick   <= 1'b0;
		end else begin
			tq_tick <= tick;
			if (init_active || tick) begin
				pre_cnt_q <= 6'h00;
			end else begin
				pre_cnt_q <= pre_cnt_q + 6'h01;
			end
		end
	end

	// segment length is code plus one quanta; counter runs 0..code
	always_comb begin
		case (phase_q)
			CBT_SEG1: seg_last = segment_one_len; // [RULE_08]
			CBT_SEG2: seg_last = {1'b0, phase_segment_two_len}; // [RULE_07]
			default:  seg_last = 4'h0;
		endcase
	end
	assign seg_done = tick && (tq_cnt_q == seg_last);

	// sync, seg1, seg2: total 1+seg1+seg2 quanta per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q  <= CBT_SYNC;
			tq_cnt_q <= 4'h0;
		end else if (init_active) begin
			phase_q  <= CBT_SYNC;
			tq_cnt_q <= 4'h0;
		end else if (seg_done) begin // [RULE_09] [RULE_10] [RULE_13]
			tq_cnt_q <= 4'h0;
			case (phase_q)
				CBT_SYNC: phase_q <= CBT_SEG1;
				CBT_SEG1: phase_q <= CBT_SEG2;
				default:  phase_q <= CBT_SYNC;
			endcase
		end else if (tick) begin
			tq_cnt_q <= tq_cnt_q + 4'h1;
		end
	end

	// samples in the last three quanta of seg1; last one is the sample point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_count_select_q       <= 3'h7;
			rx_bit       <= 1'b1;
			rx_bit_valid <= 1'b0;
		end else begin
			rx_bit_valid <= 1'b0;
			// widened so a 16-quantum segment one does not wrap the compare
			if (tick && phase_q == CBT_SEG1 && ({1'b0, tq_cnt_q} + 5'h02) >= {1'b0, seg_last}) begin
				sample_count_select_q <= {sample_count_select_q[1:0], rx_s2_q};
			end
			if (seg_done && phase_q == CBT_SEG1) begin
				rx_bit_valid <= 1'b1;
				if (sample_count_select) begin
					rx_bit <= majority3({sample_count_select_q[1:0], rx_s2_q}); // [RULE_04] [RULE_05]
				end else begin
					rx_bit <= rx_s2_q; // [RULE_03]
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_acknowledge <= 1'b0;
		end else begin
			init_acknowledge <= init_ack_q;
		end
	end

	AST_WRITE_GATED: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
		!init_active |=> $stable(timing_q))
		else $error("timing changed outside init mode");
	AST_SINGLE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
		(seg_done && phase_q == CBT_SEG1 && !sample_count_select) |=> rx_bit == $past(rx_s2_q))
		else $error("single sample mismatch");
	AST_MAJ: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
		(seg_done && phase_q == CBT_SEG1 && sample_count_select)
		|=> rx_bit == majority3({$past(sample_count_select_q[1:0]), $past(rx_s2_q)}))
		else $error("majority mismatch");
	AST_PRESCALE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
		tick && !init_active |-> pre_cnt_q == tq_prescaler_q)
		else $error("prescaler count wrong");
	AST_INIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
		init_active |=> phase_q == CBT_SYNC && tq_cnt_q == 4'h0)
		else $error("bit timing ran in init");
	AST_SEG_BOUND: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
		tq_cnt_q <= seg_last || phase_q == CBT_SYNC)
		else $error("segment overrun");
	AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		(seg_done && phase_q == CBT_SYNC && !init_active) |=> phase_q == CBT_SEG1)
		else $error("sync not followed by seg1");
	AST_VALID_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
		rx_bit_valid |=> !rx_bit_valid)
		else $error("valid longer than one cycle");
	AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
		pready |=> !pready)
		else $error("pready held longer than one cycle");
	AST_TICK_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
		tq_tick && tq_prescaler_q != 6'h00 |=> !tq_tick)
		else $error("quantum tick too long");
	COV_INIT: cover property (@(posedge pclk) disable iff (!presetn) init_active);
	COV_LONG_SEG1: cover property (@(posedge pclk) disable iff (!presetn) rx_bit_valid && segment_one_len == 4'hf);
	COV_TRIPLE: cover property (@(posedge pclk) disable iff (!presetn) rx_bit_valid && sample_count_select);
	COV_SINGLE: cover property (@(posedge pclk) disable iff (!presetn) rx_bit_valid && !sample_count_select);
endmodule

// ---- cbt_can_node.sv ----
// far-side node model driving the receive pin
`timescale 1ns/1ns
module cbt_can_node (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       rx_bit_valid,
	input  wire logic       tq_tick,
	input  wire logic       bit_val,
	input  wire logic       glitch_en,
	input  wire logic [5:0] bitq,
	input  wire logic [7:0] qlen,
	output logic            can_rx
);
	logic       v_q;
	logic       g_q;
	logic [5:0] cnt_q;
	logic [7:0] gt_q;
	// next bit launched just after a sample, far from the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v_q <= 1'b1;
			g_q <= 1'b0;
			cnt_q <= 6'h00;
			gt_q <= 8'h00;
		end else if (rx_bit_valid) begin
			v_q <= bit_val;
			g_q <= glitch_en;
			cnt_q <= 6'h00;
			gt_q <= 8'h00;
		end else begin
			if (tq_tick)
				cnt_q <= cnt_q + 6'h01;
			if (tq_tick && cnt_q == bitq - 6'h02)
				gt_q <= 8'h01;
			else if (gt_q != 8'h00)
				gt_q <= gt_q + 8'h01;
		end
	end
	// glitch covers only the sample-point quantum, not the two before it
	assign can_rx = v_q ^ (g_q && gt_q >= qlen / 2 && gt_q < qlen / 2 + qlen - 8'h02);
endmodule

// ---- tb_top.sv ----
// self-checking bench for the bit timing block
`timescale 1ns/1ns
`include "cbt_map.svh"
module tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, can_rx, rx_bit, rx_bit_valid, tq_tick, init_acknowledge;
	logic        bit_val = 0, glitch_en = 0;
	logic [5:0]  bitq = 6'h05;
	logic [7:0]  qlen = 8'h08, tv;
	logic [2:0]  hv, hg;
	int          mismatches = 0, checks_done = 0;
	time         tp;
	always #4 pclk = ~pclk;
	cbt_bit_timing u_cbt_bit_timing (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx(can_rx), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
		.tq_tick(tq_tick), .init_acknowledge(init_acknowledge));
	cbt_can_node u_cbt_can_node (.pclk(pclk), .presetn(presetn), .rx_bit_valid(rx_bit_valid),
		.tq_tick(tq_tick), .bit_val(bit_val), .glitch_en(glitch_en), .bitq(bitq), .qlen(qlen),
		.can_rx(can_rx));
	task automatic final_report();
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {a[9:0], 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		// look between edges, where the registered answer has settled
		@(negedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 50)
			mismatches++;
		r = prdata;
		chk({31'h0, pslverr}, 32'h0);
		@(posedge pclk);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic set_init(input logic on);
		int n;
		apb(1, `CBT_OFS_CTRL, {31'h0, on});
		n = 0;
		while (init_acknowledge !== on && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, init_acknowledge}, {31'h0, on});
	endtask
	task automatic wait_valid();
		int n;
		n = 0;
		@(negedge pclk);
		while (rx_bit_valid !== 1'b1 && n < 4000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 4000)
			mismatches++;
		@(posedge pclk);
	endtask
	initial begin
		#(8 * 80000);
		mismatches++;
		final_report();
	end
	initial begin
		r = $urandom(40898);
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, `CBT_OFS_TIMING, 0);
		chk(r, 32'h0);
		apb(1, `CBT_OFS_TIMING, 32'hb5);
		apb(0, `CBT_OFS_TIMING, 0);
		chk(r, 32'h0);
		apb(0, 12'h007, 0);
		chk(r, 32'h0);
		for (int c = 0; c < 4; c++) begin
			// valid codes only, segment one of 4+ quanta keeps three-sample mode legal
			tv = c == 0 ? 8'h13 : c == 1 ? 8'hff : {1'($urandom), 3'(1 + $urandom % 7), 4'(3 + $urandom % 13)};
			qlen = 8'(8 + $urandom % 25);
			set_init(1);
			apb(1, `CBT_OFS_PRESCALE, 32'(qlen - 1));
			apb(1, `CBT_OFS_TIMING, {24'h0, tv});
			apb(0, `CBT_OFS_TIMING, 0);
			chk(r, {24'h0, tv});
			set_init(0);
			apb(1, `CBT_OFS_TIMING, {24'h0, ~tv});
			apb(0, `CBT_OFS_TIMING, 0);
			chk(r, {24'h0, tv});
			bitq = 6'(3 + tv[6:4] + tv[3:0]);
			for (int n = 0; n < 9; n++) begin
				wait_valid();
				if (n >= 3) begin
					chk({31'h0, rx_bit}, {31'h0, hv[1] ^ (hg[1] & ~tv[7])});
					chk(32'(($time - tp) / 8), 32'(bitq * qlen));
				end
				tp = $time;
				hv = {hv[1:0], 1'($urandom)};
				hg = {hg[1:0], 1'($urandom)};
				bit_val <= hv[0];
				glitch_en <= hg[0];
			end
		end
		final_report();
	end
endmodule
